// ==== verilog/boot_sequencer.sv ====
`timescale 1ns/10ps
module boot_sequencer #(
  parameter int SETTLE_CYC = boot_seq_pkg::SETTLE_CYC
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  // Strap pin
  input  wire logic        i_clk_src_sel,
  // Probe engine
  output logic             o_probe_req,
  output logic [2:0]       o_probe_src,
  output logic             o_probe_wide,
  output logic [7:0]       o_serial_clk_div,
  output logic [6:0]       o_i2c_target,
  output logic [2:0]       o_ext_bus_sel,
  input  wire logic        i_probe_done,
  input  wire logic [15:0] i_probe_sig,
  // Image stream
  input  wire logic        i_img_valid,
  input  wire logic [15:0] i_img_data,
  input  wire logic        i_img_last,
  output logic             o_img_ready,
  // Register section writes
  output logic             o_cfg_valid,
  output logic [15:0]      o_cfg_addr,
  output logic [15:0]      o_cfg_data,
  // Memory writes
  output logic             o_mem_valid,
  output logic [23:0]      o_mem_addr,
  output logic [15:0]      o_mem_data,
  // Clock generator
  output logic             o_pll_bypass,
  output logic             o_pll_pwr,
  output logic [11:0]      o_pll_mult,
  output logic [1:0]       o_pll_mult_low,
  output logic             o_pll_in_div_en,
  output logic             o_pll_out_div8_en,
  output logic             o_pll_out_div_en,
  output logic [4:0]       o_pll_out_div,
  // Power and idle
  output logic             o_clock_output_pin_slow_slew,
  output logic             o_clock_output_pin_en,
  output logic             o_periph_idle,
  output logic             o_memory_port_idle,
  output logic             o_hwa_idle,
  output logic [5:0]       o_periph_clk_en,
  output logic             o_bg_trim,
  // Processor
  output logic [23:0]      o_fetch_addr,
  output logic             o_rom_map_mode,
  output logic             o_jump,
  output logic             o_boot_done,
  output logic             o_sram31_reserved
);
  typedef struct packed {
    logic [2:0] src;
    logic       wide;
    logic [2:0] external_bus_selection;
  } probe_t;

  // Probe table in the fixed search order
  function automatic probe_t probe_info(input logic [2:0] idx);
    probe_t p;
    p = '{src: boot_seq_pkg::SRC_NOR, wide: 1'b1, external_bus_selection: boot_seq_pkg::EXTERNAL_BUS_SELECTION_RST};
    case (idx)
      3'h0: p.src = boot_seq_pkg::SRC_NOR;
      3'h1: p = '{boot_seq_pkg::SRC_NAND, 1'b0, boot_seq_pkg::EXTERNAL_BUS_SELECTION_RST};
      3'h2: p = '{boot_seq_pkg::SRC_SPI, 1'b0, boot_seq_pkg::EXTERNAL_BUS_SELECTION_MODE_A};
      3'h3: p = '{boot_seq_pkg::SRC_SPI, 1'b1, boot_seq_pkg::EXTERNAL_BUS_SELECTION_MODE_A};
      3'h4: p = '{boot_seq_pkg::SRC_SPI, 1'b0, boot_seq_pkg::EXTERNAL_BUS_SELECTION_MODE_B};
      3'h5: p = '{boot_seq_pkg::SRC_SPI, 1'b1, boot_seq_pkg::EXTERNAL_BUS_SELECTION_MODE_B};
      3'h6: p = '{boot_seq_pkg::SRC_I2C, 1'b0, boot_seq_pkg::EXTERNAL_BUS_SELECTION_RST};
      default: p = '{boot_seq_pkg::SRC_CARD, 1'b0, boot_seq_pkg::EXTERNAL_BUS_SELECTION_RST};
    endcase
    return p;
  endfunction

  boot_seq_pkg::state_t state_ff, nxt_state;
  logic [2:0]  idx_ff, nxt_idx;
  probe_t      pr_ff, nxt_pr;
  logic        strap_s1_ff, strap_s2_ff, strap_ff, nxt_strap;
  logic        req_ff, nxt_req, bypass_ff, nxt_bypass, pwr_ff, nxt_pwr;
  logic [11:0] mult_ff, nxt_mult;
  logic        div_on_ff, nxt_div_on, slew_ff, nxt_slew, ckout_ff, nxt_ckout;
  logic        idle_ff, nxt_idle, trim_ff, nxt_trim, tstart_ff, nxt_tstart;
  logic [5:0]  pclk_ff, nxt_pclk;
  logic [15:0] ncfg_ff, nxt_ncfg, caddr_ff, nxt_caddr, cdata_ff, nxt_cdata, mdata_ff, nxt_mdata;
  logic        cval_ff, nxt_cval, mval_ff, nxt_mval, jump_ff, nxt_jump, done_ff, nxt_done;
  logic [23:0] entry_ff, nxt_entry, maddr_ff, nxt_maddr, fetch_ff, nxt_fetch;
  logic        f_valid, f_rd, t_done, sig_ok, streaming;
  logic [16:0] f_data;

  img_fifo #(.W(boot_seq_pkg::FIFO_W), .D(boot_seq_pkg::FIFO_D)) i_img_fifo (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_valid   (i_img_valid),
    .i_data    ({i_img_last, i_img_data}),
    .o_ready   (o_img_ready),
    .o_valid   (f_valid),
    .o_data    (f_data),
    .i_ready   (f_rd)
  );

  settle_timer #(.CYCLES(SETTLE_CYC)) i_settle_timer (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_start   (tstart_ff),
    .o_done    (t_done)
  );

  assign streaming = (state_ff inside {boot_seq_pkg::ST_CFG_N, boot_seq_pkg::ST_CFG_A,
                      boot_seq_pkg::ST_CFG_D, boot_seq_pkg::ST_ENT_H,
                      boot_seq_pkg::ST_ENT_L, boot_seq_pkg::ST_LOAD});
  assign f_rd      = streaming;
  assign sig_ok    = (i_probe_sig == boot_seq_pkg::SIG_VALUE);

  always_comb begin
    nxt_state  = state_ff;
    nxt_idx    = idx_ff;
    nxt_strap  = strap_ff;
    nxt_req    = req_ff;
    nxt_bypass = bypass_ff;
    nxt_pwr    = pwr_ff;
    nxt_mult   = mult_ff;
    nxt_div_on = div_on_ff;
    nxt_slew   = slew_ff;
    nxt_ckout  = ckout_ff;
    nxt_idle   = idle_ff;
    nxt_trim   = 1'b0;
    nxt_tstart = 1'b0;
    nxt_ncfg   = ncfg_ff;
    nxt_caddr  = caddr_ff;
    nxt_cdata  = cdata_ff;
    nxt_cval   = 1'b0;
    nxt_mdata  = mdata_ff;
    nxt_mval   = 1'b0;
    nxt_entry  = entry_ff;
    nxt_maddr  = maddr_ff;
    nxt_jump   = 1'b0;
    nxt_done   = done_ff;
    nxt_fetch  = fetch_ff;
    case (state_ff)
      // Starts on its own after every reset
      boot_seq_pkg::ST_FETCH: nxt_state = boot_seq_pkg::ST_SLEW;
      boot_seq_pkg::ST_SLEW: begin
        nxt_slew  = 1'b1;
        nxt_state = boot_seq_pkg::ST_IDLE;
      end
      boot_seq_pkg::ST_IDLE: begin
        nxt_idle  = 1'b1;
        nxt_strap = strap_s2_ff;
        nxt_state = boot_seq_pkg::ST_CLK;
      end
      boot_seq_pkg::ST_CLK: begin
        if (!strap_ff) begin
          nxt_pwr    = 1'b1;
          nxt_bypass = 1'b0;
          nxt_mult   = boot_seq_pkg::PLL_MULT_12M;
          nxt_div_on = 1'b1;
        end else begin
          nxt_bypass = 1'b1;
        end
        nxt_state = boot_seq_pkg::ST_TRIM;
      end
      boot_seq_pkg::ST_TRIM: begin
        nxt_trim  = 1'b1;
        nxt_state = boot_seq_pkg::ST_CKOFF;
      end
      boot_seq_pkg::ST_CKOFF: begin
        nxt_ckout = 1'b0;
        nxt_idx   = '0;
        nxt_req   = 1'b1;
        nxt_state = boot_seq_pkg::ST_PROBE;
      end
      // One source at a time; wait for its verdict
      boot_seq_pkg::ST_PROBE: begin
        if (i_probe_done) begin
          nxt_req = 1'b0;
          if (sig_ok) begin
            nxt_state = boot_seq_pkg::ST_CFG_N;
          end else if (idx_ff == boot_seq_pkg::LAST_PROBE) begin
            nxt_state = boot_seq_pkg::ST_USB_CLK;
          end else begin
            nxt_idx = idx_ff + 3'h1;
            nxt_req = 1'b1;
          end
        end
      end
      boot_seq_pkg::ST_CFG_N: if (f_valid) begin
        nxt_ncfg  = f_data[15:0];
        nxt_state = (f_data[15:0] == 16'h0000) ? boot_seq_pkg::ST_ENT_H : boot_seq_pkg::ST_CFG_A;
      end
      boot_seq_pkg::ST_CFG_A: if (f_valid) begin
        nxt_caddr = f_data[15:0];
        nxt_state = boot_seq_pkg::ST_CFG_D;
      end
      boot_seq_pkg::ST_CFG_D: if (f_valid) begin
        nxt_cdata = f_data[15:0];
        nxt_cval  = 1'b1;
        nxt_ncfg  = ncfg_ff - 16'h0001;
        nxt_state = (ncfg_ff == 16'h0001) ? boot_seq_pkg::ST_ENT_H : boot_seq_pkg::ST_CFG_A;
      end
      boot_seq_pkg::ST_ENT_H: if (f_valid) begin
        nxt_entry[23:16] = f_data[7:0];
        nxt_state        = boot_seq_pkg::ST_ENT_L;
      end
      boot_seq_pkg::ST_ENT_L: if (f_valid) begin
        nxt_entry[15:0] = f_data[15:0];
        // One below base so every payload word steps once, even after a stream gap
        nxt_maddr       = boot_seq_pkg::LOAD_BASE - 24'h000001;
        nxt_state       = boot_seq_pkg::ST_LOAD;
      end
      boot_seq_pkg::ST_LOAD: if (f_valid) begin
        nxt_mdata = f_data[15:0];
        nxt_mval  = 1'b1;
        nxt_maddr = maddr_ff + 24'h000001;
        if (f_data[16]) begin
          nxt_tstart = 1'b1;
          nxt_state  = boot_seq_pkg::ST_SETTLE;
        end
      end
      // Code may not run before the full interval
      boot_seq_pkg::ST_SETTLE: if (t_done && !tstart_ff) nxt_state = boot_seq_pkg::ST_JUMP;
      boot_seq_pkg::ST_JUMP: begin
        nxt_fetch = entry_ff;
        nxt_jump  = 1'b1;
        nxt_done  = 1'b1;
        nxt_state = boot_seq_pkg::ST_RUN;
      end
      boot_seq_pkg::ST_RUN: nxt_state = boot_seq_pkg::ST_RUN;
      boot_seq_pkg::ST_USB_CLK: begin
        nxt_pwr    = 1'b1;
        nxt_bypass = 1'b0;
        nxt_div_on = 1'b1;
        nxt_mult   = strap_ff ? boot_seq_pkg::PLL_MULT_USB1 : boot_seq_pkg::PLL_MULT_USB0;
        nxt_req    = 1'b1;
        nxt_state  = boot_seq_pkg::ST_USB;
      end
      // Only a device reset leaves this poll without a signature
      boot_seq_pkg::ST_USB: if (i_probe_done && sig_ok) begin
        nxt_req   = 1'b0;
        nxt_state = boot_seq_pkg::ST_CFG_N;
      end
      default: nxt_state = boot_seq_pkg::ST_FETCH;
    endcase
    nxt_pr      = probe_info(nxt_idx);
    nxt_pclk    = '0;
    // USB stays the source through its own load
    if (nxt_state inside {boot_seq_pkg::ST_USB_CLK, boot_seq_pkg::ST_USB} || pr_ff.src == boot_seq_pkg::SRC_USB) begin
      nxt_pr = '{boot_seq_pkg::SRC_USB, 1'b0, boot_seq_pkg::EXTERNAL_BUS_SELECTION_RST};
    end
    // Clock only the source under query or load
    if ((nxt_req || nxt_state inside {boot_seq_pkg::ST_CFG_N, boot_seq_pkg::ST_CFG_A,
         boot_seq_pkg::ST_CFG_D, boot_seq_pkg::ST_ENT_H, boot_seq_pkg::ST_ENT_L,
         boot_seq_pkg::ST_LOAD}) && !nxt_done) begin
      nxt_pclk = 6'h01 << nxt_pr.src;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      strap_s1_ff <= 1'b0;
      strap_s2_ff <= 1'b0;
    end else begin
      strap_s1_ff <= i_clk_src_sel;
      strap_s2_ff <= strap_s1_ff;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff  <= boot_seq_pkg::ST_FETCH;
      idx_ff    <= '0;
      pr_ff     <= '{boot_seq_pkg::SRC_NOR, 1'b1, boot_seq_pkg::EXTERNAL_BUS_SELECTION_RST};
      strap_ff  <= 1'b0;
      req_ff    <= 1'b0;
      bypass_ff <= 1'b1;
      pwr_ff    <= 1'b0;
      mult_ff   <= boot_seq_pkg::PLL_MULT_RST;
      div_on_ff <= 1'b0;
      slew_ff   <= 1'b0;
      ckout_ff  <= 1'b1;
      idle_ff   <= 1'b0;
      trim_ff   <= 1'b0;
      tstart_ff <= 1'b0;
      pclk_ff   <= '0;
      ncfg_ff   <= '0;
      caddr_ff  <= '0;
      cdata_ff  <= '0;
      cval_ff   <= 1'b0;
      mdata_ff  <= '0;
      mval_ff   <= 1'b0;
      entry_ff  <= '0;
      maddr_ff  <= '0;
      jump_ff   <= 1'b0;
      done_ff   <= 1'b0;
      fetch_ff  <= boot_seq_pkg::RESET_VECTOR;
    end else begin
      state_ff  <= nxt_state;
      idx_ff    <= nxt_idx;
      pr_ff     <= nxt_pr;
      strap_ff  <= nxt_strap;
      req_ff    <= nxt_req;
      bypass_ff <= nxt_bypass;
      pwr_ff    <= nxt_pwr;
      mult_ff   <= nxt_mult;
      div_on_ff <= nxt_div_on;
      slew_ff   <= nxt_slew;
      ckout_ff  <= nxt_ckout;
      idle_ff   <= nxt_idle;
      trim_ff   <= nxt_trim;
      tstart_ff <= nxt_tstart;
      pclk_ff   <= nxt_pclk;
      ncfg_ff   <= nxt_ncfg;
      caddr_ff  <= nxt_caddr;
      cdata_ff  <= nxt_cdata;
      cval_ff   <= nxt_cval;
      mdata_ff  <= nxt_mdata;
      mval_ff   <= nxt_mval;
      entry_ff  <= nxt_entry;
      maddr_ff  <= nxt_maddr;
      jump_ff   <= nxt_jump;
      done_ff   <= nxt_done;
      fetch_ff  <= nxt_fetch;
    end
  end

  assign o_probe_req        = req_ff;
  assign o_probe_src        = pr_ff.src;
  assign o_probe_wide       = pr_ff.wide;
  assign o_ext_bus_sel      = pr_ff.external_bus_selection;
  assign o_serial_clk_div   = (pr_ff.src == boot_seq_pkg::SRC_I2C) ? boot_seq_pkg::I2C_DIV
                                                                     : boot_seq_pkg::SPI_DIV;
  assign o_i2c_target       = boot_seq_pkg::I2C_TARGET;
  assign o_cfg_valid        = cval_ff;
  assign o_cfg_addr         = caddr_ff;
  assign o_cfg_data         = cdata_ff;
  assign o_mem_valid        = mval_ff;
  assign o_mem_addr         = maddr_ff;
  assign o_mem_data         = mdata_ff;
  assign o_pll_bypass       = bypass_ff;
  assign o_pll_pwr          = pwr_ff;
  assign o_pll_mult         = mult_ff;
  assign o_pll_mult_low     = boot_seq_pkg::PLL_MULT_LOW;
  assign o_pll_in_div_en    = 1'b0;
  assign o_pll_out_div8_en  = div_on_ff;
  assign o_pll_out_div_en   = div_on_ff;
  assign o_pll_out_div      = boot_seq_pkg::PLL_OUT_DIV;
  assign o_clock_output_pin_slow_slew = slew_ff;
  assign o_clock_output_pin_en        = ckout_ff;
  assign o_periph_idle      = idle_ff;
  assign o_memory_port_idle       = idle_ff;
  assign o_hwa_idle         = idle_ff;
  assign o_periph_clk_en    = pclk_ff;
  assign o_bg_trim          = trim_ff;
  assign o_fetch_addr       = fetch_ff;
  assign o_rom_map_mode     = boot_seq_pkg::ROM_MAP_RESET;
  assign o_jump             = jump_ff;
  assign o_boot_done        = done_ff;
  assign o_sram31_reserved  = !done_ff;

  // Helper: cycles since timer start
  logic [31:0] since_ff;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) since_ff <= '0;
    else if (tstart_ff) since_ff <= '0;
    else if (since_ff != 32'hFFFFFFFF) since_ff <= since_ff + 32'h1;
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  a_vector_hold: assert property (!o_boot_done |-> o_fetch_addr == 24'hFFFF00 && o_rom_map_mode == 1'b0)
    else $error("fetch address left reset vector early");
  a_strap_pll: assert property ($rose(o_bg_trim) |-> (strap_ff ? o_pll_bypass
      : (!o_pll_bypass && o_pll_mult == 12'h2ED && o_pll_out_div8_en)))
    else $error("clock setup does not match strap");
  a_slew_idle: assert property ($rose(o_bg_trim) |-> o_clock_output_pin_slow_slew && o_periph_idle && o_hwa_idle)
    else $error("idle or slew not set before trim");
  a_clock_output_pin_off: assert property (o_probe_req |-> !o_clock_output_pin_en)
    else $error("clock output on during probe");
  a_one_clock: assert property ($onehot0(o_periph_clk_en))
    else $error("more than one peripheral clock on");
  a_bad_sig: assert property (state_ff == boot_seq_pkg::ST_PROBE && i_probe_done && !sig_ok
      |=> state_ff != boot_seq_pkg::ST_CFG_N)
    else $error("load began on bad signature");
  a_spi_mode: assert property (o_probe_req && o_probe_src == 3'h2
      |-> (o_ext_bus_sel == 3'h5 || o_ext_bus_sel == 3'h6) && o_serial_clk_div == 8'h28)
    else $error("serial probe setup wrong");
  a_i2c_rate: assert property (o_probe_req && o_probe_src == 3'h3 |-> o_serial_clk_div == 8'h32
      && o_i2c_target == 7'h50)
    else $error("two-wire probe setup wrong");
  a_settle_min: assert property ($rose(o_jump) |-> since_ff >= 32'(SETTLE_CYC))
    else $error("jump before settling interval");
  a_handoff_off: assert property (o_jump |-> ##1 o_periph_clk_en == 6'h00 && o_periph_idle
      && o_fetch_addr == entry_ff && !o_sram31_reserved)
    else $error("hand-off state wrong");
  a_usb_stuck: assert property (state_ff == boot_seq_pkg::ST_USB && !(i_probe_done && sig_ok)
      |=> state_ff == boot_seq_pkg::ST_USB)
    else $error("left USB poll without signature");

  c_nor_boot: cover property ($rose(o_jump) && idx_ff == 3'h0);
  c_i2c_boot: cover property ($rose(o_jump) && idx_ff == 3'h6);
  c_usb_poll: cover property (state_ff == boot_seq_pkg::ST_USB && i_probe_done);
  c_cfg_write: cover property (o_cfg_valid);
endmodule

// ==== verilog/boot_seq_pkg.sv ====
package boot_seq_pkg;
  localparam int          CLK_HZ        = 20_000_000;
  localparam logic [23:0] RESET_VECTOR  = 24'hFFFF00;
  localparam logic        ROM_MAP_RESET = 1'h0;
  localparam int          SPI_HZ        = 500_000;
  localparam int          I2C_HZ        = 400_000;
  localparam logic [7:0]  SPI_DIV       = 8'(CLK_HZ / SPI_HZ);
  localparam logic [7:0]  I2C_DIV       = 8'(CLK_HZ / I2C_HZ);
  localparam logic [6:0]  I2C_TARGET    = 7'h50;
  // PLL settings
  localparam logic [11:0] PLL_MULT_12M  = 12'h2ED;
  localparam logic [11:0] PLL_MULT_USB0 = 12'h8C9;
  localparam logic [11:0] PLL_MULT_USB1 = 12'h005;
  localparam logic [1:0]  PLL_MULT_LOW  = 2'h0;
  localparam logic [4:0]  PLL_OUT_DIV   = 5'h00;
  localparam logic [11:0] PLL_MULT_RST  = 12'h000;
  localparam logic [2:0]  EXTERNAL_BUS_SELECTION_MODE_A   = 3'h5;
  localparam logic [2:0]  EXTERNAL_BUS_SELECTION_MODE_B   = 3'h6;
  localparam logic [2:0]  EXTERNAL_BUS_SELECTION_RST      = 3'h0;
  // Settling interval
  localparam int          SETTLE_MS     = 200;
  localparam int          SETTLE_CYC    = (CLK_HZ / 1000) * SETTLE_MS;
  // Image format
  localparam logic [15:0] SIG_VALUE     = 16'h55AA;
  localparam logic [23:0] LOAD_BASE     = 24'h000100;
  localparam int          FIFO_W        = 17;
  localparam int          FIFO_D        = 32;
  localparam logic [2:0]  LAST_PROBE    = 3'h7;

  typedef enum logic [2:0] {
    SRC_NOR  = 3'h0,
    SRC_NAND = 3'h1,
    SRC_SPI  = 3'h2,
    SRC_I2C  = 3'h3,
    SRC_CARD = 3'h4,
    SRC_USB  = 3'h5
  } src_t;

  typedef enum logic [4:0] {
    ST_FETCH   = 5'h00,
    ST_SLEW    = 5'h01,
    ST_IDLE    = 5'h02,
    ST_CLK     = 5'h03,
    ST_TRIM    = 5'h04,
    ST_CKOFF   = 5'h05,
    ST_PROBE   = 5'h06,
    ST_CFG_N   = 5'h07,
    ST_CFG_A   = 5'h08,
    ST_CFG_D   = 5'h09,
    ST_ENT_H   = 5'h0A,
    ST_ENT_L   = 5'h0B,
    ST_LOAD    = 5'h0C,
    ST_SETTLE  = 5'h0D,
    ST_JUMP    = 5'h0E,
    ST_RUN     = 5'h0F,
    ST_USB_CLK = 5'h10,
    ST_USB     = 5'h11
  } state_t;
endpackage

// ==== verilog/img_fifo.sv ====
`timescale 1ns/10ps
module img_fifo #(
  parameter int W = 17,
  parameter int D = 32
) (
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  // Fill side
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  // Drain side
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic          push, pop;

  assign o_ready = (cnt_ff != (AW+1)'(D));
  assign o_valid = (cnt_ff != '0);
  assign o_data  = mem[rd_ff];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_comb begin
    nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd  = pop ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage needs no reset; occupancy guards reads
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ff] <= i_data;
    end
  end
endmodule

// ==== verilog/settle_timer.sv ====
`timescale 1ns/10ps
module settle_timer #(
  parameter int CYCLES = 4_000_000
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_nrst,
  // Control
  input  wire logic i_start,
  output logic      o_done
);
  logic [31:0] cnt_ff, nxt_cnt;
  logic        run_ff, nxt_run, done_ff, nxt_done;

  assign o_done = done_ff;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_run  = run_ff;
    nxt_done = done_ff;
    if (i_start) begin
      nxt_cnt  = '0;
      nxt_run  = 1'b1;
      nxt_done = 1'b0;
    end else if (run_ff) begin
      nxt_cnt = cnt_ff + 32'h1;
      if (nxt_cnt >= 32'(CYCLES)) begin
        nxt_run  = 1'b0;
        nxt_done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_ff  <= '0;
      run_ff  <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      run_ff  <= nxt_run;
      done_ff <= nxt_done;
    end
  end
endmodule

// ==== verif/boot_src_model.sv ====
`timescale 1ns/10ps
module boot_src_model (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  // Probe side
  input  wire logic [3:0]  i_good_step,
  input  wire logic        i_req,
  output logic             o_done,
  output logic [15:0]      o_sig,
  // Image side
  input  wire logic        i_ready,
  output logic             o_valid,
  output logic [15:0]      o_data,
  output logic             o_last
);
  // Header N=1, one pair, entry 12_3456, two payload words
  localparam logic [15:0] IMG [7] = '{16'h0001, 16'h1234, 16'hBEEF, 16'h0012, 16'h3456, 16'hC0DE, 16'hF00D};
  logic [3:0] step;
  logic [3:0] idx;
  logic [1:0] dly;
  logic       go;

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      {step, idx, dly, go, o_done, o_valid, o_last} <= '0;
      o_sig  <= 16'h0000;
      o_data <= 16'h0000;
    end else begin
      o_done <= 1'b0;
      o_sig  <= ~o_sig;
      if (i_req && !o_done) begin
        dly <= dly + 2'h1;
        // Odd steps answer slowly
        if (dly == {step[0], 1'b0}) begin
          dly    <= 2'h0;
          o_done <= 1'b1;
          o_sig  <= (step == i_good_step) ? boot_seq_pkg::SIG_VALUE : boot_seq_pkg::SIG_VALUE ^ 16'h0001;
          go     <= step == i_good_step;
          step   <= (step == 4'hE) ? step : step + 4'h1;
        end
      end
      if (go && idx < 4'h7 && (!o_valid || i_ready)) begin
        o_valid <= 1'b1;
        o_data  <= IMG[idx];
        o_last  <= idx == 4'h6;
        idx     <= idx + 4'h1;
      end else if (o_valid && i_ready) begin
        o_valid <= 1'b0;
        o_data  <= ~o_data;
      end
    end
  end
endmodule

// ==== verif/boot_sequencer_bench.sv ====
`timescale 1ns/10ps
module boot_sequencer_bench;
  logic i_clk_sys = 0, i_nrst = 0, i_clk_src_sel = 1, i_probe_done, i_img_valid, i_img_last;
  logic o_probe_req, o_probe_wide, o_img_ready, o_cfg_valid, o_mem_valid, o_pll_bypass, o_pll_pwr, o_pll_in_div_en;
  logic o_pll_out_div8_en, o_pll_out_div_en, o_clock_output_pin_slow_slew, o_clock_output_pin_en, o_periph_idle, o_memory_port_idle, o_hwa_idle;
  logic o_bg_trim, o_rom_map_mode, o_jump, o_boot_done, o_sram31_reserved;
  logic [15:0] i_probe_sig, i_img_data, o_cfg_addr, o_cfg_data, o_mem_data;
  logic [23:0] o_mem_addr, o_fetch_addr;
  logic [11:0] o_pll_mult;
  logic [7:0]  o_serial_clk_div;
  logic [6:0]  o_i2c_target;
  logic [5:0]  o_periph_clk_en;
  logic [4:0]  o_pll_out_div;
  logic [2:0]  o_probe_src, o_ext_bus_sel;
  logic [1:0]  o_pll_mult_low;
  logic [3:0]  good = 4'h6;
  logic [13:0] log_q[$];
  logic [31:0] cfg_w, mem_w;
  logic        trim_seen;
  int mismatches = 0, comparisons = 0, cyc = 0, t_load = 0;
  // Probe record: divider, source, width (serial and parallel only), bus selection
  localparam logic [13:0] EXP [8] = '{14'h1408, 14'h1410, 14'h1425, 14'h142D, 14'h1426, 14'h142E, 14'h1930, 14'h1440};

  always #25 i_clk_sys = ~i_clk_sys;
  boot_sequencer #(.SETTLE_CYC(20)) i_boot_sequencer (.*);
  boot_src_model i_boot_src_model (.i_clk_sys, .i_nrst, .i_good_step(good), .i_req(o_probe_req), .o_done(i_probe_done),
    .o_sig(i_probe_sig), .i_ready(o_img_ready), .o_valid(i_img_valid), .o_data(i_img_data), .o_last(i_img_last));

  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    // Trim must come while the clock output is still on
    if (!i_nrst) trim_seen <= 1'b0;
    else if (o_bg_trim && o_clock_output_pin_en && !o_probe_req) trim_seen <= 1'b1;
    if (i_probe_done && o_probe_req)
      log_q.push_back({o_serial_clk_div[6:0], o_probe_src, o_probe_wide & (o_probe_src < 3'h3), o_ext_bus_sel});
    if (o_cfg_valid) cfg_w <= {o_cfg_addr, o_cfg_data};
    if (o_mem_valid) begin
      mem_w  <= {o_mem_addr[15:0], o_mem_data};
      t_load <= cyc;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_probes(input int n);
    chk(log_q.size(), n);
    for (int i = 0; i < n; i++) chk(log_q[i], EXP[i]);
  endtask

  task automatic boot_reset(input logic strap, input logic [3:0] g);
    @(posedge i_clk_sys);
    i_nrst <= 1'b0;
    i_clk_src_sel <= strap;
    good <= g;
    repeat (10) @(posedge i_clk_sys);
    log_q.delete();
    chk({o_fetch_addr, o_pll_bypass, o_rom_map_mode}, {24'hFFFF00, 2'b10});
    i_nrst <= 1'b1;
  endtask

  task automatic boot_from_two_wire;
    boot_reset(1'b1, 4'h6);
    for (int i = 0; i < 600 && o_jump !== 1'b1; i++) begin @(posedge i_clk_sys); #1; end
    chk_probes(7);
    chk(o_i2c_target, 7'h50);
    chk(cfg_w, 32'h1234BEEF);
    chk(mem_w, 32'h0101F00D);
    chk({o_jump, o_fetch_addr}, {1'b1, 24'h123456});
    chk(cyc - t_load >= 20, 1);
    chk({o_boot_done, o_sram31_reserved, o_periph_clk_en}, {2'b10, 6'h00});
    chk({o_periph_idle, o_memory_port_idle, o_hwa_idle, o_pll_bypass, o_clock_output_pin_en}, 5'h1E);
  endtask

  task automatic boot_none_valid;
    boot_reset(1'b0, 4'hF);
    for (int i = 0; i < 40 && o_probe_req !== 1'b1; i++) begin @(posedge i_clk_sys); #1; end
    chk(trim_seen, 1'b1);
    chk({o_pll_mult, o_pll_mult_low, o_pll_in_div_en, o_pll_out_div8_en, o_pll_out_div_en, o_pll_out_div},
        {12'h2ED, 2'h0, 3'h3, 5'h00});
    chk({o_clock_output_pin_slow_slew, o_clock_output_pin_en, o_periph_idle, o_pll_pwr, o_pll_bypass}, 5'h16);
    for (int i = 0; i < 200 && !(o_probe_src === 3'h5 && o_probe_req === 1'b1); i++) begin @(posedge i_clk_sys); #1; end
    chk_probes(8);
    chk({o_pll_mult, o_pll_bypass, o_pll_pwr}, {12'h8C9, 2'b01});
    repeat (30) @(posedge i_clk_sys);
    #1;
    chk({o_probe_src, o_probe_req, o_boot_done, o_sram31_reserved}, {3'h5, 3'b101});
  endtask

  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    boot_from_two_wire;
    boot_none_valid;
    end_sim;
  end

  // Both scenarios need well under 1000 cycles
  initial begin
    #(3000 * 50);
    mismatches++;
    end_sim;
  end
endmodule
